// ### aux_timer_control_unit.sv
// auxiliary 16-bit timer/counter: control register, count, capture/reload, baud ticks
// assumes REF_CLK is the oscillator clock and the special function bus is synchronous
`timescale 1ns/100ps
module aux_timer_control_unit (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // special function byte access
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // special function bit access
    input wire logic [7:0] SFR_BIT_ADDR,
    input wire logic SFR_BIT_WR,
    input wire logic SFR_BIT_WDATA,
    // external pins
    input wire logic COUNT_INPUT_PIN,
    input wire logic TRIGGER_PIN,
    // interrupt system
    input wire logic TIMER_IRQ_ENABLE,
    output logic TIMER_IRQ,
    // serial port clocking
    input wire logic TIMER1_OVERFLOW,
    output logic RX_BAUD_TICK,
    output logic TX_BAUD_TICK
);
    logic machine_tick, state_tick;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] mode_reg, mode_next;
    logic [15:0] count_reg, count_next;
    logic [15:0] cap_reg, cap_next;
    logic count_prev_reg, count_prev_next;
    logic trig_prev_reg, trig_prev_next;
    logic [7:0] rdata_reg, rdata_next;
    logic irq_reg, irq_next;
    logic rx_tick_reg, rx_tick_next;
    logic tx_tick_reg, tx_tick_next;
    logic baud, capture_mode, updown, up, tick, inc;
    logic count_edge, trig_fall, ext_event, wrap_up, wrap_dn;
    logic bit_hit;
    logic [7:0] wr_mask, wr_data;

    aux_timer_prescaler #(
        .MACHINE_DIV(aux_timer_pkg::OSC_PER_MACHINE),
        .STATE_DIV(aux_timer_pkg::OSC_PER_STATE)
    ) u_prescaler (
        .clk(REF_CLK),
        .resetn(RESETN),
        .machine_tick(machine_tick),
        .state_tick(state_tick)
    );

    always_comb begin
        baud = ctrl_reg[aux_timer_pkg::RX_BAUD_BIT] | ctrl_reg[aux_timer_pkg::TX_BAUD_BIT];
        capture_mode = ctrl_reg[aux_timer_pkg::CAP_RELOAD_BIT] & ~baud;
        updown = mode_reg[aux_timer_pkg::DOWN_COUNT_BIT] & ~ctrl_reg[aux_timer_pkg::CAP_RELOAD_BIT] & ~baud;
        // in up/down mode the trigger pin is the direction, not an event
        up = ~updown | TRIGGER_PIN;
        // pins are sampled once per machine cycle; a fall needs a high then a low sample
        count_prev_next = machine_tick ? COUNT_INPUT_PIN : count_prev_reg;
        trig_prev_next = machine_tick ? TRIGGER_PIN : trig_prev_reg;
        count_edge = machine_tick & count_prev_reg & ~COUNT_INPUT_PIN;
        trig_fall = machine_tick & trig_prev_reg & ~TRIGGER_PIN;
        tick = baud ? state_tick : machine_tick;
        inc = ctrl_reg[aux_timer_pkg::RUN_BIT]
            & (ctrl_reg[aux_timer_pkg::COUNTER_SEL_BIT] ? count_edge : tick);
        wrap_up = inc & up & (count_reg == aux_timer_pkg::COUNT_TOP);
        wrap_dn = inc & ~up & (count_reg == cap_reg);
        ext_event = ctrl_reg[aux_timer_pkg::EXT_ENABLE_BIT] & ~baud & ~updown & trig_fall;

        // count and capture/reload words
        count_next = count_reg;
        cap_next = cap_reg;
        if (inc) begin
            if (wrap_up) begin
                count_next = capture_mode ? aux_timer_pkg::WORD_RESET : cap_reg;
            end else if (wrap_dn) begin
                count_next = aux_timer_pkg::COUNT_TOP;
            end else begin
                count_next = up ? count_reg + 16'h0001 : count_reg - 16'h0001;
            end
        end
        if (ext_event) begin
            if (capture_mode) begin
                cap_next = count_reg;
            end else begin
                count_next = cap_reg;
            end
        end
        // software byte writes take precedence over hardware updates of the same byte
        if (SFR_WR) begin
            unique case (SFR_ADDR)
                aux_timer_pkg::COUNT_LOW_ADDR: count_next[7:0] = SFR_WDATA;
                aux_timer_pkg::COUNT_HIGH_ADDR: count_next[15:8] = SFR_WDATA;
                aux_timer_pkg::CAP_LOW_ADDR: cap_next[7:0] = SFR_WDATA;
                aux_timer_pkg::CAP_HIGH_ADDR: cap_next[15:8] = SFR_WDATA;
                default: ;
            endcase
        end

        // control register: byte write or single bit write
        bit_hit = SFR_BIT_WR
            & (SFR_BIT_ADDR[7:aux_timer_pkg::BIT_ROW_LSB] == aux_timer_pkg::CONTROL_ADDR[7:aux_timer_pkg::BIT_ROW_LSB]);
        wr_mask = aux_timer_pkg::BYTE_ZERO;
        wr_data = SFR_WDATA;
        if (SFR_WR && SFR_ADDR == aux_timer_pkg::CONTROL_ADDR) begin
            wr_mask = ~aux_timer_pkg::BYTE_ZERO;
        end else if (bit_hit) begin
            wr_mask = aux_timer_pkg::BIT_ONE << SFR_BIT_ADDR[aux_timer_pkg::BIT_ROW_LSB-1:0];
            wr_data = {8{SFR_BIT_WDATA}};
        end
        ctrl_next = (ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
        // hardware sets win over a software clear in the same cycle
        if ((wrap_up | wrap_dn) & ~baud) begin
            ctrl_next[aux_timer_pkg::OVERFLOW_BIT] = 1'b1;
        end
        if (updown & (wrap_up | wrap_dn)) begin
            ctrl_next[aux_timer_pkg::EXT_EVENT_BIT] = ~ctrl_reg[aux_timer_pkg::EXT_EVENT_BIT];
        end
        if (ext_event) begin
            ctrl_next[aux_timer_pkg::EXT_EVENT_BIT] = 1'b1;
        end

        mode_next = mode_reg;
        if (SFR_WR && SFR_ADDR == aux_timer_pkg::MODE_ADDR) begin
            mode_next[aux_timer_pkg::DOWN_COUNT_BIT] = SFR_WDATA[aux_timer_pkg::DOWN_COUNT_BIT];
        end

        // interrupt request; the flag in up/down mode is only a 17th count bit
        irq_next = TIMER_IRQ_ENABLE & (ctrl_reg[aux_timer_pkg::OVERFLOW_BIT]
            | (ctrl_reg[aux_timer_pkg::EXT_EVENT_BIT] & ~updown));

        rx_tick_next = ctrl_reg[aux_timer_pkg::RX_BAUD_BIT] ? wrap_up : TIMER1_OVERFLOW;
        tx_tick_next = ctrl_reg[aux_timer_pkg::TX_BAUD_BIT] ? wrap_up : TIMER1_OVERFLOW;

        unique case (SFR_ADDR)
            aux_timer_pkg::CONTROL_ADDR: rdata_next = ctrl_reg;
            aux_timer_pkg::MODE_ADDR: rdata_next = mode_reg;
            aux_timer_pkg::CAP_LOW_ADDR: rdata_next = cap_reg[7:0];
            aux_timer_pkg::CAP_HIGH_ADDR: rdata_next = cap_reg[15:8];
            aux_timer_pkg::COUNT_LOW_ADDR: rdata_next = count_reg[7:0];
            aux_timer_pkg::COUNT_HIGH_ADDR: rdata_next = count_reg[15:8];
            default: rdata_next = aux_timer_pkg::BYTE_ZERO;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_reg <= aux_timer_pkg::CONTROL_RESET;
            mode_reg <= aux_timer_pkg::MODE_RESET;
            count_reg <= aux_timer_pkg::WORD_RESET;
            cap_reg <= aux_timer_pkg::WORD_RESET;
            count_prev_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
            rdata_reg <= aux_timer_pkg::BYTE_ZERO;
            irq_reg <= 1'b0;
            rx_tick_reg <= 1'b0;
            tx_tick_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            mode_reg <= mode_next;
            count_reg <= count_next;
            cap_reg <= cap_next;
            count_prev_reg <= count_prev_next;
            trig_prev_reg <= trig_prev_next;
            rdata_reg <= rdata_next;
            irq_reg <= irq_next;
            rx_tick_reg <= rx_tick_next;
            tx_tick_reg <= tx_tick_next;
        end
    end

    assign SFR_RDATA = rdata_reg;
    assign TIMER_IRQ = irq_reg;
    assign RX_BAUD_TICK = rx_tick_reg;
    assign TX_BAUD_TICK = tx_tick_reg;
endmodule // aux_timer_control_unit

// ### aux_timer_pkg.sv
// constants for the auxiliary 16-bit timer/counter control unit
// assumes an 8-bit special function register space with bit-addressable rows
package aux_timer_pkg;
    // register addresses in special function space
    localparam logic [7:0] CONTROL_ADDR = 8'hC8;
    localparam logic [7:0] MODE_ADDR = 8'hC9;
    localparam logic [7:0] CAP_LOW_ADDR = 8'hCA;
    localparam logic [7:0] CAP_HIGH_ADDR = 8'hCB;
    localparam logic [7:0] COUNT_LOW_ADDR = 8'hCC;
    localparam logic [7:0] COUNT_HIGH_ADDR = 8'hCD;
    // reset values and fixed word/byte constants
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [15:0] COUNT_TOP = 16'hFFFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BIT_ONE = 8'h01;
    // control register fields
    localparam int OVERFLOW_BIT = 7;
    localparam int EXT_EVENT_BIT = 6;
    localparam int RX_BAUD_BIT = 5;
    localparam int TX_BAUD_BIT = 4;
    localparam int EXT_ENABLE_BIT = 3;
    localparam int RUN_BIT = 2;
    localparam int COUNTER_SEL_BIT = 1;
    localparam int CAP_RELOAD_BIT = 0;
    // mode register field
    localparam int DOWN_COUNT_BIT = 0;
    // bit address row: upper five bits select the register
    localparam int BIT_ROW_LSB = 3;
    // oscillator periods per machine cycle and per state time
    localparam int OSC_PER_MACHINE = 12;
    localparam int OSC_PER_STATE = 2;
endpackage

// ### aux_timer_prescaler.sv
// machine-cycle and state-time tick generator
// assumes clk is the oscillator clock; ticks are one-cycle pulses
`timescale 1ns/100ps
module aux_timer_prescaler #(
    parameter int MACHINE_DIV = aux_timer_pkg::OSC_PER_MACHINE,
    parameter int STATE_DIV = aux_timer_pkg::OSC_PER_STATE
) (
    input wire logic clk,
    input wire logic resetn,
    output logic machine_tick,
    output logic state_tick
);
    logic [7:0] machine_cnt_reg, machine_cnt_next;
    logic [7:0] state_cnt_reg, state_cnt_next;
    logic machine_tick_reg, machine_tick_next;
    logic state_tick_reg, state_tick_next;

    always_comb begin
        machine_tick_next = (machine_cnt_reg == 8'(MACHINE_DIV - 1));
        machine_cnt_next = machine_tick_next ? 8'h00 : machine_cnt_reg + 8'h01;
        state_tick_next = (state_cnt_reg == 8'(STATE_DIV - 1));
        state_cnt_next = state_tick_next ? 8'h00 : state_cnt_reg + 8'h01;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            machine_cnt_reg <= 8'h00;
            state_cnt_reg <= 8'h00;
            machine_tick_reg <= 1'b0;
            state_tick_reg <= 1'b0;
        end else begin
            machine_cnt_reg <= machine_cnt_next;
            state_cnt_reg <= state_cnt_next;
            machine_tick_reg <= machine_tick_next;
            state_tick_reg <= state_tick_next;
        end
    end

    assign machine_tick = machine_tick_reg;
    assign state_tick = state_tick_reg;
endmodule // aux_timer_prescaler

// ### aux_timer_checker.sv
// port-level assertions for the auxiliary timer control unit
// assumes it is bound into aux_timer_control_unit and sees only that module's ports
`timescale 1ns/100ps
module aux_timer_checker (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESETN,
    // register access
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SFR_BIT_WR,
    // interrupt and serial clocking
    input wire logic TIMER_IRQ_ENABLE,
    input wire logic TIMER_IRQ,
    input wire logic TIMER1_OVERFLOW,
    input wire logic RX_BAUD_TICK,
    input wire logic TX_BAUD_TICK
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence s_ctl_write;
        SFR_WR && SFR_ADDR == 8'hC8;
    endsequence
    sequence s_ctl_read;
        SFR_ADDR == 8'hC8 && !SFR_WR && !SFR_BIT_WR;
    endsequence
    property p_reset_quiet;
        $rose(RESETN) |-> SFR_RDATA == 8'h00 && !TIMER_IRQ && !RX_BAUD_TICK && !TX_BAUD_TICK;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not idle after reset");
    property p_unmapped;
        (SFR_ADDR < 8'hC8 || SFR_ADDR > 8'hCD) |=> SFR_RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // control bits 5:0 are software-only, so a write must read back exactly
    property p_ctl_store;
        s_ctl_write ##1 s_ctl_read |=> SFR_RDATA[5:0] == $past(SFR_WDATA[5:0], 2);
    endproperty
    a_ctl_store: assert property (p_ctl_store) else $error("control write lost");
    property p_irq_off;
        !TIMER_IRQ_ENABLE |=> !TIMER_IRQ;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("request while disabled");
    property p_irq_on;
        $past(SFR_ADDR) == 8'hC8 && SFR_RDATA[7] && $past(TIMER_IRQ_ENABLE) |-> TIMER_IRQ;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("flag without request");
    property p_rx_timer1;
        // the register stage is held in reset one edge longer than the disable sees
        $past(RESETN) && $past(SFR_ADDR) == 8'hC8 && !SFR_RDATA[5] |-> RX_BAUD_TICK == $past(TIMER1_OVERFLOW);
    endproperty
    a_rx_timer1: assert property (p_rx_timer1) else $error("receive clock source wrong");
    property p_tx_timer1;
        $past(RESETN) && $past(SFR_ADDR) == 8'hC8 && !SFR_RDATA[4] |-> TX_BAUD_TICK == $past(TIMER1_OVERFLOW);
    endproperty
    a_tx_timer1: assert property (p_tx_timer1) else $error("transmit clock source wrong");
    property p_baud_no_flag;
        $past(SFR_ADDR) == 8'hC8 && SFR_ADDR == 8'hC8 && (SFR_RDATA[5] || SFR_RDATA[4]) && !SFR_RDATA[7]
            && !$past(SFR_WR) && !$past(SFR_BIT_WR) |=> !SFR_RDATA[7];
    endproperty
    a_baud_no_flag: assert property (p_baud_no_flag) else $error("overflow flag set in baud mode");
endmodule // aux_timer_checker
bind aux_timer_control_unit aux_timer_checker u_chk (.REF_CLK, .RESETN, .SFR_ADDR, .SFR_WR, .SFR_WDATA,
    .SFR_RDATA, .SFR_BIT_WR, .TIMER_IRQ_ENABLE, .TIMER_IRQ, .TIMER1_OVERFLOW, .RX_BAUD_TICK, .TX_BAUD_TICK);

// ### aux_timer_pins_model.sv
// far-side model: count pin, trigger pin and a timer 1 overflow source
// assumes the bench calls its tasks; pins idle high as pulled-up port pins
`timescale 1ns/100ps
module aux_timer_pins_model (
    // clock
    input wire logic clk,
    // pins and serial clock source
    output logic count_pin,
    output logic trig_pin,
    output logic t1_ovf
);
    int div = 0;
    initial begin
        count_pin = 1'b1;
        trig_pin = 1'b1;
        t1_ovf = 1'b0;
    end
    // free-running stand-in for timer 1 overflows
    always @(posedge clk) begin
        #1 div = (div == 6) ? 0 : div + 1;
        t1_ovf = (div == 0);
    end
    // levels held two machine cycles so one sample per machine cycle never misses them
    task automatic fall_trigger();
        @(posedge clk);
        #1 trig_pin = 1'b0;
        repeat (24) @(posedge clk);
        #1 trig_pin = 1'b1;
        repeat (24) @(posedge clk);
    endtask
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 count_pin = 1'b0;
            repeat (24) @(posedge clk);
            #1 count_pin = 1'b1;
            repeat (24) @(posedge clk);
        end
    endtask
endmodule // aux_timer_pins_model

// ### aux_timer_control_unit_tb.sv
// self-checking bench for the auxiliary timer control unit
// assumes the checker is bound in and the pin model sits on the external side
`timescale 1ns/100ps
module aux_timer_control_unit_tb;
    logic REF_CLK, RESETN, SFR_WR, SFR_BIT_WR, SFR_BIT_WDATA, TIMER_IRQ_ENABLE, TIMER_IRQ;
    logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, SFR_BIT_ADDR, v0, v1;
    logic COUNT_INPUT_PIN, TRIGGER_PIN, TIMER1_OVERFLOW, RX_BAUD_TICK, TX_BAUD_TICK;
    logic win = 1'b0;
    int n_fail = 0, checks = 0, cyc = 0, n_rx = 0, n_tx = 0;
    aux_timer_control_unit u_dut (.REF_CLK, .RESETN, .SFR_ADDR, .SFR_WR, .SFR_WDATA, .SFR_RDATA,
        .SFR_BIT_ADDR, .SFR_BIT_WR, .SFR_BIT_WDATA, .COUNT_INPUT_PIN, .TRIGGER_PIN, .TIMER_IRQ_ENABLE,
        .TIMER_IRQ, .TIMER1_OVERFLOW, .RX_BAUD_TICK, .TX_BAUD_TICK);
    aux_timer_pins_model u_pins (.clk(REF_CLK), .count_pin(COUNT_INPUT_PIN), .trig_pin(TRIGGER_PIN),
        .t1_ovf(TIMER1_OVERFLOW));
    initial begin
        REF_CLK = 1'b0;
        forever #4 REF_CLK = ~REF_CLK;
    end
    task automatic print_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    always @(posedge REF_CLK) begin
        cyc++;
        n_rx += (win && RX_BAUD_TICK) ? 1 : 0;
        n_tx += (win && TX_BAUD_TICK) ? 1 : 0;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        #1 SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1'b1;
        @(posedge REF_CLK);
        #1 SFR_WR = 1'b0;
    endtask
    task automatic bw(input logic [7:0] a, input logic d);
        @(posedge REF_CLK);
        #1 SFR_BIT_ADDR = a;
        SFR_BIT_WDATA = d;
        SFR_BIT_WR = 1'b1;
        @(posedge REF_CLK);
        #1 SFR_BIT_WR = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge REF_CLK);
        #1 SFR_ADDR = a;
        @(posedge REF_CLK);
        #1 v = SFR_RDATA;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask
    initial begin
        {RESETN, SFR_WR, SFR_BIT_WR, SFR_BIT_WDATA, SFR_WDATA} = '0;
        {SFR_ADDR, SFR_BIT_ADDR, TIMER_IRQ_ENABLE} = {8'hC8, 8'hC8, 1'b1};
        repeat (8) @(posedge REF_CLK);
        #1 RESETN = 1'b1;
        rd_chk(8'hC8, 8'h00);
        rd_chk(8'hC0, 8'h00);
        $display("reset test done");
        wr(8'hCA, 8'h34); wr(8'hCB, 8'h12); wr(8'hCC, 8'hFE); wr(8'hCD, 8'hFF); wr(8'hC8, 8'h04);
        repeat (40) @(posedge REF_CLK);
        rd_chk(8'hCD, 8'h12);
        rd(8'hCC, v0);
        repeat (118) @(posedge REF_CLK);
        rd(8'hCC, v1);
        chk(v1 - v0, 8'h0A);
        rd_chk(8'hC8, 8'h84);
        chk({7'h00, TIMER_IRQ}, 8'h01);
        TIMER_IRQ_ENABLE = 1'b0;
        repeat (2) @(posedge REF_CLK);
        #1 chk({7'h00, TIMER_IRQ}, 8'h00);
        TIMER_IRQ_ENABLE = 1'b1;
        bw(8'hCF, 1'b0);
        rd_chk(8'hC8, 8'h04);
        $display("reload test done");
        wr(8'hC8, 8'h09); wr(8'hCC, 8'hCD); wr(8'hCD, 8'hAB);
        u_pins.fall_trigger();
        rd_chk(8'hCA, 8'hCD);
        rd_chk(8'hCB, 8'hAB);
        rd_chk(8'hC8, 8'h49);
        chk({7'h00, TIMER_IRQ}, 8'h01);
        bw(8'hCE, 1'b0);
        wr(8'hC8, 8'h01); wr(8'hCC, 8'h55);
        u_pins.fall_trigger();
        rd_chk(8'hCA, 8'hCD);
        rd_chk(8'hC8, 8'h01);
        $display("capture test done");
        wr(8'hC8, 8'h06); wr(8'hCC, 8'h00); wr(8'hCD, 8'h00);
        u_pins.pulse_count(3);
        rd_chk(8'hCC, 8'h03);
        $display("counter test done");
        // capture select left set: baud mode must still reload, or no ticks would come
        wr(8'hCA, 8'hF0); wr(8'hCB, 8'hFF); wr(8'hCC, 8'hF0); wr(8'hCD, 8'hFF); wr(8'hC8, 8'h35);
        repeat (64) @(posedge REF_CLK);
        #1 win = 1'b1;
        repeat (320) @(posedge REF_CLK);
        #1 win = 1'b0;
        chk(n_rx[7:0], 8'h0A);
        chk(n_tx[7:0], 8'h0A);
        rd_chk(8'hC8, 8'h35);
        $display("baud test done");
        wr(8'hC8, 8'h00); wr(8'hC9, 8'h01); wr(8'hCA, 8'h34); wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFF); wr(8'hCD, 8'hFF); wr(8'hC8, 8'h06);
        // trigger pin idles high, so the up/down counter counts up and overflows once
        u_pins.pulse_count(1);
        rd_chk(8'hC9, 8'h01);
        rd_chk(8'hCD, 8'h12);
        rd_chk(8'hC8, 8'hC6);
        chk({7'h00, TIMER_IRQ}, 8'h01);
        bw(8'hCF, 1'b0);
        rd_chk(8'hC8, 8'h46);
        chk({7'h00, TIMER_IRQ}, 8'h00);
        $display("updown test done");
        print_verdict();
    end
endmodule // aux_timer_control_unit_tb
